// File: core/swt_pkg.sv
package swt_pkg;
    // system clock and crystal time base
    localparam int unsigned CLK_HZ      = 10_000_000;
    localparam int unsigned XTAL_HZ     = 32_768;
    localparam int unsigned CNT_W       = 24;
    localparam int unsigned PRE_W       = 15;
    localparam logic [14:0] PRE_LAST    = 15'(XTAL_HZ - 1);
    // glitch filter on the reset pin, in microseconds, then in cycles
    localparam int unsigned DEB_US      = 100;
    localparam int unsigned DEB_CYC     = (DEB_US * (CLK_HZ / 1_000_000) < 1) ? 1
                                          : DEB_US * (CLK_HZ / 1_000_000);
    localparam int unsigned DEB_W       = 11;
    localparam logic [10:0] DEB_LAST    = 11'(DEB_CYC - 1);
    // serial port: arbitrary 7-bit target address
    localparam logic [6:0]  DEV_ADDR    = 7'h32;
    localparam logic [2:0]  BIT_LAST    = 3'h7;
    localparam logic [1:0]  BYTE_LAST   = 2'h2;
    // pin positions in the filter vector
    localparam int unsigned PIN_SCL     = 0;
    localparam int unsigned PIN_SDA     = 1;
    localparam int unsigned PIN_XTAL    = 2;
    localparam int unsigned PIN_RST     = 3;
    localparam int unsigned NPIN        = 4;
    // serial port states, gray along the usual path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_AACK = 3'h3,
        ST_WR   = 3'h2,
        ST_WACK = 3'h6,
        ST_RD   = 3'h7,
        ST_RACK = 3'h5
    } swt_state_t;
endpackage

// File: core/swt_timer.sv
`timescale 1ns/100ps
// What this block does
// - timer is a 24-bit counter counting only upward
// - compare counter to wake value, interrupt on equal
// - counter advances exactly once per second
// - second tick divided from 32.768 kHz crystal
// - reset pin low holds timer, high counts
// - reset pin glitches filtered before taking effect
// - host writes wake value over the serial port
// - data line only pulled low, timed by SCL
module swt_timer #(parameter int unsigned XTAL_DIV = swt_pkg::XTAL_HZ)
(
    input  wire logic               mclk_in,     // 10 MHz system clock
    input  wire logic               arst_n_in,   // async reset, active low
    input  wire logic               xtal_in,     // 32.768 kHz crystal clock
    input  wire logic               trst_n_in,   // timer reset pin, active low
    input  wire logic               scl_in,      // serial clock from host
    input  wire logic               sda_in,      // serial data line level
    output logic                    sda_out,     // always low when enabled
    output logic                    sda_oe_out,  // high while pulling low
    output logic                    int_out,     // wake-up match, active high
    output logic [23:0]             count_out    // live timer value
);
    localparam int unsigned N = swt_pkg::NPIN;
    localparam logic [14:0] PRE_END = 15'(XTAL_DIV - 1); // last crystal edge of one second

    logic [N-1:0]           s1_q;      // first sync stage, read by s2 only
    logic [N-1:0]           s2_q;      // second sync stage
    logic [N-1:0]           s3_q;      // third sync stage
    logic [N-1:0]           f_q;       // accepted pin levels
    logic [N-1:0]           fp_q;      // accepted levels one cycle back
    logic [14:0]            pre_q;     // crystal edge prescaler
    logic                   run_q;     // debounced reset pin level
    logic [10:0]            deb_q;     // stability counter
    logic [23:0]            cnt_q;     // the timer
    logic [23:0]            wake_q;    // committed wake value
    logic [23:0]            stage_q;   // bytes in flight from the host
    logic [23:0]            snap_q;    // timer snapshot for reads
    logic                   int_q;
    logic                   oe_q;
    swt_pkg::swt_state_t    st_q;
    logic [2:0]             bit_q;     // bit within byte
    logic [1:0]             idx_q;     // byte within transfer
    logic [7:0]             sh_q;      // shift register
    logic                   rw_q;      // 1 = host reads
    logic                   armed_q;   // an address bit was clocked in since start

    // byte of a 24-bit word, most significant first
    function automatic logic [7:0] byte_of(input logic [23:0] v, input logic [1:0] i);
        byte_of = (i == 2'h0) ? v[23:16] : (i == 2'h1) ? v[15:8] : v[7:0];
    endfunction

    // edge and bus condition strobes from accepted levels
    logic scl_rise, scl_fall, i2c_start, i2c_stop, xtal_rise, tick;
    assign scl_rise  = f_q[swt_pkg::PIN_SCL] & ~fp_q[swt_pkg::PIN_SCL];
    assign scl_fall  = ~f_q[swt_pkg::PIN_SCL] & fp_q[swt_pkg::PIN_SCL];
    assign i2c_start = f_q[swt_pkg::PIN_SCL] & fp_q[swt_pkg::PIN_SCL]
                       & ~f_q[swt_pkg::PIN_SDA] & fp_q[swt_pkg::PIN_SDA];
    assign i2c_stop  = f_q[swt_pkg::PIN_SCL] & fp_q[swt_pkg::PIN_SCL]
                       & f_q[swt_pkg::PIN_SDA] & ~fp_q[swt_pkg::PIN_SDA];
    assign xtal_rise = f_q[swt_pkg::PIN_XTAL] & ~fp_q[swt_pkg::PIN_XTAL];
    // one pulse per 32768 crystal edges
    assign tick      = run_q & xtal_rise & (pre_q == PRE_END);

    // three-stage sync; a change counts once stages two and three agree
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            s1_q <= '1;   // idle bus and released reset pin read high
            s2_q <= '1;
            s3_q <= '1;
            f_q  <= '1;
            fp_q <= '1;
        end
        else
        begin
            s1_q <= {trst_n_in, xtal_in, sda_in, scl_in};
            s2_q <= s1_q;
            s3_q <= s2_q;
            fp_q <= f_q;
            for (int i = 0; i < N; i++)
                if (s2_q[i] == s3_q[i])
                    f_q[i] <= s3_q[i];
        end
    end

    // reset pin filter: level must hold DEB_CYC cycles to take effect
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            run_q <= 1'b0;
            deb_q <= '0;
        end
        else if (f_q[swt_pkg::PIN_RST] == run_q)
            deb_q <= '0;           // bounce restarts the wait
        else if (deb_q == swt_pkg::DEB_LAST)
        begin
            run_q <= f_q[swt_pkg::PIN_RST];
            deb_q <= '0;
        end
        else
            deb_q <= deb_q + 11'h1;
    end

    // prescaler, cleared while the timer is held
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            pre_q <= '0;
        else if (!run_q)
            pre_q <= '0;
        else if (xtal_rise)
            pre_q <= (pre_q == PRE_END) ? '0 : pre_q + 15'h1;
    end

    // the timer; wraps past all ones, there is no stop
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            cnt_q <= '0;
        else if (!run_q)
            cnt_q <= '0;
        else if (tick)
            cnt_q <= cnt_q + 24'h1;
    end

    // match compare, level output while equal
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            int_q <= 1'b0;
        else
            int_q <= run_q & (cnt_q == wake_q);
    end

    // serial target: write 3 bytes = wake value, read 3 bytes = timer
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            st_q    <= swt_pkg::ST_IDLE;
            bit_q   <= '0;
            idx_q   <= '0;
            sh_q    <= '0;
            rw_q    <= 1'b0;
            armed_q <= 1'b0;
            oe_q    <= 1'b0;
            stage_q <= '0;
            wake_q  <= '0;
            snap_q  <= '0;
        end
        else if (i2c_stop)
        begin
            st_q <= swt_pkg::ST_IDLE;
            oe_q <= 1'b0;
        end
        else if (i2c_start)
        begin
            // repeated start also lands here
            st_q  <= swt_pkg::ST_ADDR;
            bit_q <= '0;
            idx_q <= '0;
            oe_q  <= 1'b0;
            armed_q <= 1'b0;  // the clock fall that ends the start is no bit
        end
        else if (scl_rise)
        begin
            // sample only on rising clock
            unique case (st_q)
                swt_pkg::ST_ADDR, swt_pkg::ST_WR:
                begin
                    sh_q  <= {sh_q[6:0], f_q[swt_pkg::PIN_SDA]};
                    bit_q <= bit_q + 3'h1;
                    armed_q <= 1'b1;
                end
                swt_pkg::ST_RACK:
                    rw_q <= ~f_q[swt_pkg::PIN_SDA]; // host ack keeps read going
                default:
                    ;
            endcase
        end
        else if (scl_fall)
        begin
            // data line changes only while clock low
            unique case (st_q)
                swt_pkg::ST_ADDR:
                    if (bit_q == 3'h0 && armed_q)  // eight bits seen, not the start fall
                    begin
                        if (sh_q[7:1] == swt_pkg::DEV_ADDR)
                        begin
                            st_q   <= swt_pkg::ST_AACK;
                            rw_q   <= sh_q[0];
                            oe_q   <= 1'b1;
                            snap_q <= cnt_q;  // coherent multi-byte read
                        end
                        else
                            st_q <= swt_pkg::ST_IDLE;
                    end
                swt_pkg::ST_AACK, swt_pkg::ST_RACK:
                    if (rw_q)
                    begin
                        st_q  <= swt_pkg::ST_RD;
                        sh_q  <= byte_of(snap_q, idx_q) << 1;
                        oe_q  <= (byte_of(snap_q, idx_q) < 8'h80); // msb clear: pull low
                        bit_q <= 3'h1;
                        idx_q <= (idx_q == swt_pkg::BYTE_LAST) ? '0 : idx_q + 2'h1;
                    end
                    else
                    begin
                        // host nack on a read also ends up here
                        st_q  <= (st_q == swt_pkg::ST_AACK) ? swt_pkg::ST_WR
                                                            : swt_pkg::ST_IDLE;
                        oe_q  <= 1'b0;
                        bit_q <= '0;
                    end
                swt_pkg::ST_WR:
                    if (bit_q == 3'h0)
                    begin
                        st_q <= swt_pkg::ST_WACK;
                        oe_q <= 1'b1;
                        stage_q <= {stage_q[15:0], sh_q};
                        if (idx_q == swt_pkg::BYTE_LAST)
                            wake_q <= {stage_q[15:0], sh_q};
                        idx_q <= (idx_q == swt_pkg::BYTE_LAST) ? '0 : idx_q + 2'h1;
                    end
                swt_pkg::ST_WACK:
                begin
                    st_q <= swt_pkg::ST_WR;
                    oe_q <= 1'b0;
                end
                swt_pkg::ST_RD:
                begin
                    if (bit_q == 3'h0)
                    begin
                        st_q <= swt_pkg::ST_RACK;
                        oe_q <= 1'b0;        // release for host ack
                    end
                    else
                    begin
                        oe_q  <= ~sh_q[7];   // a one is a release, never a drive
                        sh_q  <= {sh_q[6:0], 1'b0};
                        bit_q <= bit_q + 3'h1;
                    end
                end
                default:
                begin
                    st_q <= swt_pkg::ST_IDLE;
                    oe_q <= 1'b0;
                end
            endcase
        end
    end
    assign sda_out    = 1'b0;   // open drain: level is always low
    assign sda_oe_out = oe_q;
    assign int_out    = int_q;
    assign count_out  = cnt_q;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    property p_up_only;
        ##1 cnt_q != $past(cnt_q) |-> cnt_q == $past(cnt_q) + 24'h1 || cnt_q == '0;
    endproperty
    a_up_only: assert property (p_up_only) else $error("timer moved other than up");
    property p_match;
        run_q && cnt_q == wake_q ##1 run_q |-> int_out;
    endproperty
    a_match: assert property (p_match) else $error("match without interrupt");
    property p_tick_only;
        run_q && !tick |=> cnt_q == $past(cnt_q) || !$past(run_q);
    endproperty
    a_tick_only: assert property (p_tick_only) else $error("timer moved without tick");
    property p_div;
        tick |-> xtal_rise && pre_q == PRE_END ##1 pre_q == '0;
    endproperty
    a_div: assert property (p_div) else $error("tick not at prescaler wrap");
    property p_run;
        run_q && tick ##1 run_q |-> cnt_q == $past(cnt_q) + 24'h1;
    endproperty
    a_run: assert property (p_run) else $error("tick lost while running");
    property p_filter;
        $changed(run_q) |-> $past(deb_q) == swt_pkg::DEB_LAST;
    endproperty
    a_filter: assert property (p_filter) else $error("reset level taken early");
    property p_wake;
        $changed(wake_q) |-> $past(scl_fall) && $past(st_q) == swt_pkg::ST_WR;
    endproperty
    a_wake: assert property (p_wake) else $error("wake value changed off a write");
    property p_sda;
        $rose(sda_oe_out) |-> $past(scl_fall) && !f_q[swt_pkg::PIN_SCL];
    endproperty
    a_sda: assert property (p_sda) else $error("data pulled while clock high");
    property p_clear;
        !run_q |=> cnt_q == '0 [*2];
    endproperty
    a_clear: assert property (p_clear) else $error("timer not held at zero");
endmodule

// File: test/swt_host_model.sv
`timescale 1ns/100ps
// serial port master; open drain, a released line floats high through the pull-up
module swt_host_model
(
    input  wire logic mclk_in,    // system clock, paces the bus
    input  wire logic sda_in,     // resolved data line level
    output logic      scl_out,    // serial clock, idle high
    output logic      sda_oe_out  // high while pulling data low
);
    int half = 12;  // half scl period in cycles, the bench varies it (fast or slow host)

    initial
    begin
        scl_out    = 1'b1;
        sda_oe_out = 1'b0;
    end

    // all changes land just after a clock edge
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask

    // one scl pulse; data moves only while scl is low, the line is read at the high end
    task automatic clk_bit(input logic b, output logic r);
        wait_cyc(2);  // hold data past the falling edge, the device sync lags it
        sda_oe_out = ~b;
        wait_cyc(half);
        scl_out = 1'b1;
        wait_cyc(half);
        r = sda_in;
        scl_out = 1'b0;
    endtask

    task automatic start_cond();
        wait_cyc(2);
        sda_oe_out = 1'b0;
        wait_cyc(half);
        scl_out = 1'b1;
        wait_cyc(half);
        sda_oe_out = 1'b1;  // data falls while scl high
        wait_cyc(half);
        scl_out = 1'b0;
    endtask

    task automatic stop_cond();
        wait_cyc(2);
        sda_oe_out = 1'b1;
        wait_cyc(half);
        scl_out = 1'b1;
        wait_cyc(half);
        sda_oe_out = 1'b0;  // data rises while scl high
        wait_cyc(half);
    endtask

    // byte out msb first, then the ninth pulse reads the acknowledge
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            clk_bit(d[i], r);
        clk_bit(1'b1, r);
        ack = ~r;
    endtask

    // byte in msb first; acknowledge unless it is the last one
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            clk_bit(1'b1, r);
            d[i] = r;
        end
        clk_bit(last, r);
    endtask

    // address with write, then three wake bytes msb first
    task automatic write_wake(input logic [6:0] a, input logic [23:0] w, output logic [3:0] acks);
        start_cond();
        send_byte({a, 1'b0}, acks[3]);
        for (int i = 2; i >= 0; i--)
            send_byte(w[i*8 +: 8], acks[i]);
        stop_cond();
    endtask

    // address with read, three bytes, the last refused to end the read
    task automatic read_count(input logic [6:0] a, output logic [23:0] v, output logic ack);
        start_cond();
        send_byte({a, 1'b1}, ack);
        for (int i = 2; i >= 0; i--)
            recv_byte(i == 0, v[i*8 +: 8]);
        stop_cond();
    endtask
endmodule

// File: test/swt_timer_tb_top.sv
`timescale 1ns/100ps
module swt_timer_tb_top;
    localparam int DIV  = 4096;       // crystal edges per second, cut down to keep the run short
    localparam int TICK = DIV * 4;    // one second with the crystal at four clock cycles
    logic        mclk, arst_n, xtal, trst_n, sda, dut_sda, dut_oe, host_oe, scl, int_o, ack;
    logic [23:0] count, prev, v, w;   // live timer, previous sample, read-back, wake
    logic [3:0]  acks;                // address and data acknowledges
    int          err_count, compares, seed, cyc_now, t0, n;

    always #50 mclk = ~mclk;              // 10 MHz
    always #200 xtal = ~xtal;             // fast crystal so one second fits the run
    assign sda = ~(dut_oe | host_oe);     // wired data line with pull-up
    always @(posedge mclk) cyc_now <= cyc_now + 1;

    swt_timer #(.XTAL_DIV(DIV)) i_swt_timer (.mclk_in(mclk), .arst_n_in(arst_n), .xtal_in(xtal),
        .trst_n_in(trst_n), .scl_in(scl), .sda_in(sda), .sda_out(dut_sda), .sda_oe_out(dut_oe),
        .int_out(int_o), .count_out(count));
    swt_host_model i_swt_host_model (.mclk_in(mclk), .sda_in(sda), .scl_out(scl),
        .sda_oe_out(host_oe));

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic exp_int(input logic [23:0] wk, input logic [23:0] c, input logic run);
        return run && (wk == c);
    endfunction

    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // data pin only ever pulls low; the timer never steps down except to zero
    always @(negedge mclk)
    begin
        if (dut_oe === 1'b1)
            check("sda value", dut_sda, 1'b0);
        if (arst_n && count !== prev && count !== 24'h0)
            check("count step", count, prev + 24'h1);
        prev <= count;
    end

    initial
    begin
        mclk = 0; xtal = 0; arst_n = 0; trst_n = 0; seed = 33; cyc_now = 0; prev = 0;
        cyc(8);
        arst_n = 1;
        cyc(1200);
        check("count held", count, 24'h0);
        check("int held", int_o, 1'b0);
        trst_n = 1;
        t0 = cyc_now;
        cyc(1100);
        check("int at zero", int_o, exp_int(24'h0, 24'h0, 1'b1));
        i_swt_host_model.write_wake(swt_pkg::DEV_ADDR, 24'h1, acks);
        check("write acks", acks, 4'hf);
        cyc(10);
        check("int cleared", int_o, exp_int(24'h1, 24'h0, 1'b1));
        i_swt_host_model.write_wake(swt_pkg::DEV_ADDR ^ 7'h01, 24'h0, acks);
        check("other addr", acks, 4'h0);
        check("int kept", int_o, 1'b0);
        trst_n = 0;  // short glitch, shorter than the filter
        cyc(100 + ($unsigned($random(seed)) % 700));
        trst_n = 1;
        n = 0;
        while (count === 24'h0 && n < 140000)
        begin
            cyc(1);
            n++;
        end
        n = cyc_now - t0;
        check("first second", count, 24'h1);
        check("tick time", n >= TICK + 995 && n <= TICK + 1050, 1'b1);
        cyc(3);
        check("int at match", int_o, 1'b1);
        i_swt_host_model.half = 10;
        i_swt_host_model.read_count(swt_pkg::DEV_ADDR, v, ack);
        check("read ack", ack, 1'b1);
        check("read value", v, 24'h1);
        for (int k = 0; k < 6; k++)
        begin
            i_swt_host_model.half = 10 + ($unsigned($random(seed)) % 11);
            w = (k == 0) ? 24'h0 : (k == 1) ? 24'hffffff : (k == 2) ? 24'h1 : 24'($random(seed));
            i_swt_host_model.write_wake(swt_pkg::DEV_ADDR, w, acks);
            cyc(10);
            check("int vs wake", int_o, exp_int(w, 24'h1, 1'b1));
        end
        trst_n = 0;
        cyc(1200);
        check("count cleared", count, 24'h0);
        check("int stopped", int_o, 1'b0);
        report_and_stop();
    end

    // hang guard, well beyond one second plus the serial traffic
    initial
    begin
        repeat (60000) @(posedge mclk);  // about twice the expected run
        err_count++;
        report_and_stop();
    end
endmodule
